// >>> hdl/cap_select.v
`timescale 1ns/10ps
`include "torque_cap_defines.vh"
// picks the effective cap for one direction
module cap_select (
  input  wire [9:0] internal_i,
  input  wire [9:0] external_i,
  input  wire       ext_on_i,
  input  wire [9:0] cmd_value_i,
  input  wire       cmd_value_on_i,
  input  wire [9:0] cmd_bit_value_i,
  input  wire       cmd_bit_on_i,
  input  wire [9:0] motor_max_i,
  output wire [9:0] cap_o
);
  wire [9:0] s0;
  wire [9:0] s1;
  wire [9:0] s2;

  // smallest of every active method, internal always applies
  assign s0 = (ext_on_i && external_i < internal_i) ? external_i
                                                    : internal_i;
  assign s1 = (cmd_value_on_i && cmd_value_i < s0) ? cmd_value_i : s0;
  assign s2 = (cmd_bit_on_i && cmd_bit_value_i < s1) ? cmd_bit_value_i
                                                     : s1;
  // motor maximum overrides any larger selection
  assign cap_o = (s2 > motor_max_i) ? motor_max_i : s2;
endmodule

// >>> hdl/input_sync.v
`timescale 1ns/10ps
// two-stage synchroniser for asynchronous pins
module input_sync (
  input  wire clk_i,
  input  wire rst_i,
  input  wire async_i,
  output wire sync_o
);
  reg stage1_reg;
  reg stage2_reg;

  // first stage is read only by the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= async_i;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_o = stage2_reg;
endmodule

// >>> hdl/torque_cap_defines.vh
`ifndef TORQUE_CAP_DEFINES_VH
`define TORQUE_CAP_DEFINES_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------------
`define OFS_FWD_INT        8'h00
`define OFS_REV_INT        8'h04
`define OFS_FWD_EXT        8'h08
`define OFS_REV_EXT        8'h0C
`define OFS_ALLOC          8'h10
`define OFS_CMD            8'h14
`define OFS_MOTOR_MAX      8'h18
`define OFS_EFFECTIVE      8'h1C
`define OFS_STATUS         8'h20
`define OFS_IRQ_STATUS     8'h24
`define OFS_IRQ_MASK       8'h28

// ----------------------------------------------------------------------
// reset values and ranges, in 1 % steps of rated torque
// ----------------------------------------------------------------------
`define CAP_W              10
`define CAP_MAX_SETTING    10'h320
`define RST_INT_CAP        10'h320
`define RST_EXT_CAP        10'h064
`define RST_MOTOR_MAX      10'h12C
`define RST_CMD_CAP        10'h320

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ALLOC_FWD_BIT      0
`define ALLOC_REV_BIT      1
`define ALLOC_OUT_BIT      2
`define CMD_CAP_EN_BIT     10
`define CMD_FWD_BIT        11
`define CMD_REV_BIT        12
`define ST_FWD_CLAMP_BIT   0
`define ST_REV_CLAMP_BIT   1
`define ST_ACTIVE_BIT      2
`define IRQ_W              3
`define IRQ_ENTER_BIT      0
`define IRQ_LEAVE_BIT      1
`define IRQ_RANGE_BIT      2

`endif

// >>> hdl/torque_limit_selector.v
`timescale 1ns/10ps
`include "torque_cap_defines.vh"
// Contract
// - forward and reverse internal caps always apply, 0..800, reset 800
// - every cap value counts in 1 % steps of rated torque
// - forward and reverse external caps, 0..800, reset 100, immediate
// - forward request on: forward cap is min of internal and external
// - forward request off: forward cap is internal setting only
// - reverse request on: reverse cap is min of internal and external
// - any selected cap above motor maximum becomes motor maximum
// - limit-active output on while torque is clamped, else off
// - request inputs used only when allocated to input pins
// - limit-active output driven only when allocated to a pin
// - command cap value and command limit bits also limit torque
module torque_limit_selector (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output reg         err_o,
  input  wire        forward_limit_request_n_i,
  input  wire        reverse_limit_request_n_i,
  input  wire [15:0] torque_demand_i,
  input  wire        torque_negative_i,
  output reg  [9:0]  forward_cap_o,
  output reg  [9:0]  reverse_cap_o,
  output reg         limit_active_status_n_o,
  output reg         irq_o
);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  reg  [9:0]  forward_internal_torque_cap_reg;
  reg  [9:0]  reverse_internal_torque_cap_reg;
  reg  [9:0]  forward_external_torque_cap_reg;
  reg  [9:0]  reverse_external_torque_cap_reg;
  reg  [2:0]  alloc_reg;
  reg  [9:0]  command_torque_cap_value_reg;
  reg         cmd_cap_en_reg;
  reg         command_forward_limit_bit_reg;
  reg         command_reverse_limit_bit_reg;
  reg  [9:0]  motor_max_reg;
  reg  [2:0]  irq_status_reg;
  reg  [2:0]  irq_mask_reg;
  reg         clamp_reg;
  reg         fwd_clamp_reg;
  reg         rev_clamp_reg;
  reg  [31:0] rdata_next;
  reg  [2:0]  irq_status_next;
  reg         mapped;

  wire        fwd_req_sync;
  wire        rev_req_sync;
  wire        fwd_req_on;
  wire        rev_req_on;
  wire [9:0]  fwd_cap;
  wire [9:0]  rev_cap;
  wire        access;
  wire        wr;
  wire [9:0]  wr_cap;
  wire [9:0]  wr_cmd_cap;
  wire        wr_range_bad;
  wire        fwd_clamp;
  wire        rev_clamp;
  wire        clamp;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // cap write value saturated to the settable range
  function [9:0] sat_cap;
    input [31:0] d;
    begin
      if (d[15:0] > {6'h00, `CAP_MAX_SETTING})
        sat_cap = `CAP_MAX_SETTING;
      else
        sat_cap = d[9:0];
    end
  endfunction

  // true when address selects a given register
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // true for the four settable cap registers
  function cap_bank;
    input [7:0] a;
    begin
      cap_bank = hit(a, `OFS_FWD_INT) | hit(a, `OFS_REV_INT) |
                 hit(a, `OFS_FWD_EXT) | hit(a, `OFS_REV_EXT);
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  input_sync fwd_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (~forward_limit_request_n_i),
    .sync_o  (fwd_req_sync)
  );

  input_sync rev_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (~reverse_limit_request_n_i),
    .sync_o  (rev_req_sync)
  );

  // requests count only when allocated
  assign fwd_req_on = fwd_req_sync & alloc_reg[`ALLOC_FWD_BIT];
  assign rev_req_on = rev_req_sync & alloc_reg[`ALLOC_REV_BIT];

  // ----------------------------------------------------------------------
  // cap selection per direction
  // ----------------------------------------------------------------------
  cap_select fwd_select (
    .internal_i      (forward_internal_torque_cap_reg),
    .external_i      (forward_external_torque_cap_reg),
    .ext_on_i        (fwd_req_on),
    .cmd_value_i     (command_torque_cap_value_reg),
    .cmd_value_on_i  (cmd_cap_en_reg),
    .cmd_bit_value_i (forward_external_torque_cap_reg),
    .cmd_bit_on_i    (command_forward_limit_bit_reg),
    .motor_max_i     (motor_max_reg),
    .cap_o           (fwd_cap)
  );

  cap_select rev_select (
    .internal_i      (reverse_internal_torque_cap_reg),
    .external_i      (reverse_external_torque_cap_reg),
    .ext_on_i        (rev_req_on),
    .cmd_value_i     (command_torque_cap_value_reg),
    .cmd_value_on_i  (cmd_cap_en_reg),
    .cmd_bit_value_i (reverse_external_torque_cap_reg),
    .cmd_bit_on_i    (command_reverse_limit_bit_reg),
    .motor_max_i     (motor_max_reg),
    .cap_o           (rev_cap)
  );

  // ----------------------------------------------------------------------
  // clamp detection, demand in 1 % steps
  // ----------------------------------------------------------------------
  assign fwd_clamp = ~torque_negative_i &&
                     (torque_demand_i > {6'h00, fwd_cap});
  assign rev_clamp = torque_negative_i &&
                     (torque_demand_i > {6'h00, rev_cap});
  assign clamp     = fwd_clamp | rev_clamp;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  assign access       = cyc_i & stb_i & ~ack_o & ~err_o;
  // unmapped addresses only get err and change nothing
  assign wr           = access & mapped & we_i & (&sel_i[1:0]);
  assign wr_cap       = sat_cap(dat_i);
  // command value saturates on its own field, flag bits stay out of it
  assign wr_cmd_cap   = sat_cap({22'h000000, dat_i[9:0]});
  // out-of-range flag only for the settable cap registers
  assign wr_range_bad = wr && (dat_i[15:0] > {6'h00, `CAP_MAX_SETTING}) &&
                        cap_bank(adr_i);

  // read mux
  always @* begin
    rdata_next = 32'h0000_0000;
    mapped     = 1'b1;
    case (adr_i)
      `OFS_FWD_INT:    rdata_next[9:0] = forward_internal_torque_cap_reg;
      `OFS_REV_INT:    rdata_next[9:0] = reverse_internal_torque_cap_reg;
      `OFS_FWD_EXT:    rdata_next[9:0] = forward_external_torque_cap_reg;
      `OFS_REV_EXT:    rdata_next[9:0] = reverse_external_torque_cap_reg;
      `OFS_ALLOC:      rdata_next[2:0] = alloc_reg;
      `OFS_CMD: begin
        rdata_next[9:0]             = command_torque_cap_value_reg;
        rdata_next[`CMD_CAP_EN_BIT] = cmd_cap_en_reg;
        rdata_next[`CMD_FWD_BIT]    = command_forward_limit_bit_reg;
        rdata_next[`CMD_REV_BIT]    = command_reverse_limit_bit_reg;
      end
      `OFS_MOTOR_MAX:  rdata_next[9:0] = motor_max_reg;
      `OFS_EFFECTIVE:  rdata_next[25:0] = {fwd_cap, 6'h00, rev_cap};
      `OFS_STATUS:     rdata_next[2:0] = {clamp_reg, rev_clamp_reg,
                                          fwd_clamp_reg};
      `OFS_IRQ_STATUS: rdata_next[2:0] = irq_status_reg;
      `OFS_IRQ_MASK:   rdata_next[2:0] = irq_mask_reg;
      default:         mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // bus answer, one wait cycle free
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= access & mapped;
      err_o <= access & ~mapped;
      dat_o <= (access & mapped & ~we_i) ? rdata_next : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // register writes, effective next cycle
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      forward_internal_torque_cap_reg <= `RST_INT_CAP;
      reverse_internal_torque_cap_reg <= `RST_INT_CAP;
      forward_external_torque_cap_reg <= `RST_EXT_CAP;
      reverse_external_torque_cap_reg <= `RST_EXT_CAP;
      alloc_reg                       <= 3'h0;
      command_torque_cap_value_reg    <= `RST_CMD_CAP;
      cmd_cap_en_reg                  <= 1'b0;
      command_forward_limit_bit_reg   <= 1'b0;
      command_reverse_limit_bit_reg   <= 1'b0;
      motor_max_reg                   <= `RST_MOTOR_MAX;
      irq_mask_reg                    <= 3'h0;
    end else if (wr) begin
      case (adr_i)
        `OFS_FWD_INT: forward_internal_torque_cap_reg <= wr_cap;
        `OFS_REV_INT: reverse_internal_torque_cap_reg <= wr_cap;
        `OFS_FWD_EXT: forward_external_torque_cap_reg <= wr_cap;
        `OFS_REV_EXT: reverse_external_torque_cap_reg <= wr_cap;
        `OFS_ALLOC:   alloc_reg <= dat_i[2:0];
        `OFS_CMD: begin
          command_torque_cap_value_reg  <= wr_cmd_cap;
          cmd_cap_en_reg                <= dat_i[`CMD_CAP_EN_BIT];
          command_forward_limit_bit_reg <= dat_i[`CMD_FWD_BIT];
          command_reverse_limit_bit_reg <= dat_i[`CMD_REV_BIT];
        end
        `OFS_MOTOR_MAX: motor_max_reg <= dat_i[9:0];
        `OFS_IRQ_MASK:  irq_mask_reg  <= dat_i[2:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // sticky events, set wins over write-one-clear
  // ----------------------------------------------------------------------
  always @* begin
    irq_status_next = irq_status_reg;
    if (wr && hit(adr_i, `OFS_IRQ_STATUS))
      irq_status_next = irq_status_reg & ~dat_i[2:0];
    if (clamp & ~clamp_reg)
      irq_status_next[`IRQ_ENTER_BIT] = 1'b1;
    if (~clamp & clamp_reg)
      irq_status_next[`IRQ_LEAVE_BIT] = 1'b1;
    if (wr_range_bad)
      irq_status_next[`IRQ_RANGE_BIT] = 1'b1;
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_reg          <= 3'h0;
      clamp_reg               <= 1'b0;
      fwd_clamp_reg           <= 1'b0;
      rev_clamp_reg           <= 1'b0;
      forward_cap_o           <= `RST_INT_CAP;
      reverse_cap_o           <= `RST_INT_CAP;
      limit_active_status_n_o <= 1'b1;
      irq_o                   <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      clamp_reg      <= clamp;
      fwd_clamp_reg  <= fwd_clamp;
      rev_clamp_reg  <= rev_clamp;
      forward_cap_o  <= fwd_cap;
      reverse_cap_o  <= rev_cap;
      // low means closed, only when allocated
      limit_active_status_n_o <= ~(clamp &
                                   alloc_reg[`ALLOC_OUT_BIT]);
      // interrupt follows the status value being stored
      irq_o <= |(irq_status_next & irq_mask_reg);
    end
  end

endmodule

// >>> tb/host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// host controller: active-low limit request pins
// ---------------------------------------------------------------
module host_model (
  input  logic clk_i,
  input  logic fwd_want_i,
  input  logic rev_want_i,
  output logic forward_limit_request_n_o,
  output logic reverse_limit_request_n_o
);
  // pins close only while reduced torque is wanted
  always @(posedge clk_i) begin
    forward_limit_request_n_o <= !fwd_want_i;
    reverse_limit_request_n_o <= !rev_want_i;
  end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// torque cap selector bench
// ---------------------------------------------------------------
module tb_top;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, last_err;
  logic        ack_o, err_o, irq_o, fwd_n, rev_n, fwd_want, rev_want;
  logic        limit_active_status_n_o, torque_negative_i;
  logic [3:0]  sel_i;
  logic [7:0]  adr_i;
  logic [9:0]  forward_cap_o, reverse_cap_o;
  logic [15:0] torque_demand_i;
  logic [31:0] dat_i, dat_o, c;
  logic [31:0] rq[$];
  int          miscompares, samples_checked;

  // device and host side
  torque_limit_selector torque_limit_selector_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .forward_limit_request_n_i(fwd_n),
    .reverse_limit_request_n_i(rev_n),
    .torque_demand_i(torque_demand_i),
    .torque_negative_i(torque_negative_i),
    .forward_cap_o(forward_cap_o), .reverse_cap_o(reverse_cap_o),
    .limit_active_status_n_o(limit_active_status_n_o), .irq_o(irq_o));
  host_model host_model_i (.clk_i(clk_i), .fwd_want_i(fwd_want),
    .rev_want_i(rev_want), .forward_limit_request_n_o(fwd_n),
    .reverse_limit_request_n_o(rev_n));

  // clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  // one classic bus cycle, held until ack or err
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    // no timeout here: ack or err ends the wait, else only the watchdog
    while (!(ack_o || err_o)) @(posedge clk_i);
    last_err = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  // read data against the oldest note
  always @(posedge clk_i)
    if (ack_o && !we_i && rq.size() > 0) chk(dat_o, rq.pop_front());

  // one direction: internal, external request, unallocated pin
  task dir_run(input logic rv);
    logic [31:0] r, x;
    logic [7:0]  o;
    r = $urandom % 32'h321;
    x = $urandom % 32'h321;
    o = rv ? 8'h04 : 8'h00;
    wb(1'b1, o, r);
    wb(1'b1, o + 8'h08, x);
    tick(2);
    chk(rv ? reverse_cap_o : forward_cap_o, r);
    fwd_want <= !rv;
    rev_want <= rv;
    tick(5);
    chk(rv ? reverse_cap_o : forward_cap_o, x < r ? x : r);
    wb(1'b1, 8'h10, 32'h0);
    tick(2);
    chk(rv ? reverse_cap_o : forward_cap_o, r);
    wb(1'b1, 8'h10, 32'h3);
    fwd_want <= 1'b0;
    rev_want <= 1'b0;
    tick(5);
    $display("direction %0d done", rv);
  endtask

  // main sequence
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hF;
    dat_i = 32'h0;
    torque_demand_i = 16'h0;
    torque_negative_i = 1'b0;
    fwd_want = 1'b0;
    rev_want = 1'b0;
    void'($urandom(29573));
    tick(16);
    rst_i <= 1'b0;
    tick(1);
    rd(8'h00, 32'h320);
    rd(8'h04, 32'h320);
    rd(8'h08, 32'h64);
    rd(8'h0C, 32'h64);
    wb(1'b0, 8'h2C, 32'h0);
    chk(last_err, 32'h1);
    $display("reset values done");
    wb(1'b1, 8'h18, 32'h320);
    wb(1'b1, 8'h10, 32'h3);
    dir_run(1'b0);
    dir_run(1'b1);
    wb(1'b1, 8'h00, 32'h320);
    wb(1'b1, 8'h04, 32'h320);
    wb(1'b1, 8'h18, 32'h32);
    tick(2);
    chk(forward_cap_o, 32'h32);
    wb(1'b1, 8'h18, 32'h320);
    wb(1'b1, 8'h14, 32'h420);
    tick(2);
    chk(reverse_cap_o, 32'h20);
    wb(1'b1, 8'h08, 32'h10);
    wb(1'b1, 8'h14, 32'h820);
    tick(2);
    chk(forward_cap_o, 32'h10);
    chk(reverse_cap_o, 32'h320);
    wb(1'b1, 8'h14, 32'h320);
    $display("command caps done");
    c = 32'h1 + $urandom % 32'h190;
    wb(1'b1, 8'h00, c);
    wb(1'b1, 8'h10, 32'h7);
    wb(1'b1, 8'h28, 32'h1);
    torque_demand_i <= c[15:0] + 16'h1;
    tick(3);
    chk(limit_active_status_n_o, 32'h0);
    chk(irq_o, 32'h1);
    rd(8'h20, 32'h5);
    torque_demand_i <= c[15:0];
    tick(3);
    chk(limit_active_status_n_o, 32'h1);
    rd(8'h24, 32'h3);
    wb(1'b1, 8'h24, 32'h1);
    tick(2);
    chk(irq_o, 32'h0);
    wb(1'b1, 8'h10, 32'h3);
    torque_demand_i <= c[15:0] + 16'h1;
    tick(3);
    chk(limit_active_status_n_o, 32'h1);
    torque_demand_i <= 16'h0;
    tick(3);
    wb(1'b1, 8'h10, 32'h7);
    torque_negative_i <= 1'b1;
    torque_demand_i <= 16'h0321;
    tick(3);
    chk(limit_active_status_n_o, 32'h0);
    rd(8'h20, 32'h6);
    torque_negative_i <= 1'b0;
    torque_demand_i <= 16'h0;
    tick(3);
    wb(1'b1, 8'h24, 32'h7);
    wb(1'b1, 8'h00, 32'h3FF);
    rd(8'h00, 32'h320);
    rd(8'h24, 32'h4);
    $display("status and interrupt done");
    give_verdict;
  end

  // cut a hung run short
  initial begin
    #400000;
    miscompares++;
    give_verdict;
  end
endmodule

// >>> tb/torque_cap_properties.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// port checker for the torque cap selector
// ---------------------------------------------------------------
module torque_cap_props (
  input logic        clk_i,
  input logic        rst_i,
  input logic        cyc_i,
  input logic        stb_i,
  input logic [31:0] dat_o,
  input logic        ack_o,
  input logic        err_o,
  input logic [15:0] torque_demand_i,
  input logic [9:0]  forward_cap_o,
  input logic [9:0]  reverse_cap_o,
  input logic        limit_active_status_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // bus answers come one cycle after the request, once
  a_answer_next: assert property (cyc_i && stb_i && !ack_o && !err_o
    |=> ack_o || err_o) else $error("request not answered in time");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_answer_cause: assert property ((ack_o || err_o) |-> $past(cyc_i))
    else $error("answer without request");
  a_answer_excl: assert property (!(ack_o && err_o))
    else $error("ack and err together");
  a_data_quiet: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  // caps stay in range, no limiting without demand
  a_fwd_cap_max: assert property (forward_cap_o <= 10'h320)
    else $error("forward cap above range");
  a_rev_cap_max: assert property (reverse_cap_o <= 10'h320)
    else $error("reverse cap above range");
  a_idle_no_limit: assert property (torque_demand_i == 16'h0
    |=> limit_active_status_n_o) else $error("limit without demand");
  c_read: cover property (ack_o && dat_o != 32'h0);
  c_err: cover property (err_o);
  c_limit: cover property ($fell(limit_active_status_n_o));
endmodule

bind torque_limit_selector torque_cap_props torque_cap_props_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
  .torque_demand_i(torque_demand_i), .forward_cap_o(forward_cap_o),
  .reverse_cap_o(reverse_cap_o),
  .limit_active_status_n_o(limit_active_status_n_o));
